// ---- include/fgw_pkg.sv ----
/*
  Shared constants and types for the fuse-guarded watchdog: register map,
  control field layout, status bits, safety levels and timing counts.
  Assumes a 32-bit APB slave with 8-bit byte addresses, clocked at 50 MHz.
*/
package fgw_pkg;

  // ************************************************************
  // register map (byte addresses, one aligned word each)
  // ************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [7:0] OFF_RSTFLAG = 8'h0C;
  localparam logic [7:0] OFF_RESTART = 8'h10;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLOCK_HZ = 50_000_000;
  localparam int unsigned OSC_HZ = 1_000_000;
  localparam int unsigned PERIOD_BASE_DEF = 16_384;
  localparam int unsigned CNT_W = 21;
  localparam int unsigned CHG_WINDOW_CYC = 4;
  localparam logic [1:0] CHG_LAST = 2'(CHG_WINDOW_CYC - 1);
  localparam logic [1:0] STRAP_LAST = 2'h3;

  // ************************************************************
  // fields
  // ************************************************************
  localparam int unsigned FLAG_BIT = 0;
  localparam logic [2:0] PERIOD_RESET = 3'h0;
  localparam int unsigned STS_W = 2;

  typedef enum logic [1:0] {FGW_LVL0, FGW_LVL1, FGW_LVL2} fgw_level_e;

  typedef struct packed {
    logic [2:0] rsvd;
    logic chg_en;
    logic enable;
    logic [2:0] period;
  } fgw_ctrl_s;

  typedef struct packed {
    logic refused;
    logic timeout;
  } fgw_evt_s;

  // fuse inputs are high when programmed
  function automatic fgw_level_e fuse_level(input logic compat, input logic always_on);
    if (always_on) begin
      return FGW_LVL2;
    end
    return compat ? FGW_LVL0 : FGW_LVL1;
  endfunction : fuse_level

endpackage : fgw_pkg

// ---- hw/fgw_sync.sv ----
/*
  Two-flop level synchroniser for a bundle of asynchronous inputs.
  Assumes the inputs change slowly relative to the clock.
*/
`timescale 1ns/1ps
module fgw_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // ************************************************************
  // synchroniser
  // ************************************************************
  // first stage feeds only the second stage
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : fgw_sync

// ---- hw/fgw_watchdog.sv ----
/*
  Fuse-guarded watchdog with APB register access, sticky status with mask
  and interrupt, reset-source flag and a one-cycle chip reset pulse.
  Assumes one 50 MHz clock; the watchdog oscillator and fuses are pins.
*/
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module fgw_watchdog
  import fgw_pkg::*;
#(
  parameter int unsigned PERIOD_BASE = fgw_pkg::PERIOD_BASE_DEF
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [fgw_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fgw_pkg::DATA_W-1:0] pwdata,
  output logic [fgw_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc_clk_pin,
  input wire logic compat_fuse,
  input wire logic always_on_fuse,
  input wire logic restart_instruction,
  input wire logic chip_rst_in,
  output logic chip_rst_pulse,
  output logic irq
);
  import fgw_pkg::*;

  // ************************************************************
  // pin synchronisation
  // ************************************************************
  logic [2:0] pins_sync;
  logic osc_prev_q;
  logic osc_tick;

  fgw_sync #(.W(3)) u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .async_in({osc_clk_pin, compat_fuse, always_on_fuse}),
    .sync_out(pins_sync)
  );

  // rising edge of the oscillator, seen after two flops
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      osc_prev_q <= 1'b0;
    end else begin
      osc_prev_q <= pins_sync[2];
    end
  end
  assign osc_tick = pins_sync[2] & ~osc_prev_q;

  // ************************************************************
  // strap capture of the safety level
  // ************************************************************
  logic [1:0] strap_cnt_q;
  logic init_done_q;
  fgw_level_e level_q;
  logic strap_take;
  logic is_l0;
  logic is_l2;

  // fuses are caught only after the synchroniser has settled
  assign strap_take = ~init_done_q & (strap_cnt_q == STRAP_LAST);
  assign is_l0 = (level_q == FGW_LVL0);
  assign is_l2 = (level_q == FGW_LVL2);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      strap_cnt_q <= 2'h0;
      init_done_q <= 1'b0;
      level_q <= FGW_LVL1;
    end else begin
      if (!init_done_q) begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
      end
      if (strap_take) begin
        init_done_q <= 1'b1;
        level_q <= fuse_level(pins_sync[1], pins_sync[0]);
      end
    end
  end

  // ************************************************************
  // apb decode
  // ************************************************************
  logic acc_start;
  logic xfer_done;
  logic wr_take;
  logic sel_ctrl;
  logic sel_status;
  logic sel_mask;
  logic sel_flag;
  logic sel_restart;
  logic mapped;
  logic wr_ctrl;
  logic wr_restart;
  logic [DATA_W-1:0] rd_mux;
  fgw_ctrl_s wd;

  // one wait state; reads are sampled when pready is raised
  assign acc_start = psel & penable & ~pready & init_done_q;
  assign xfer_done = psel & penable & pready;
  assign wr_take = xfer_done & pwrite;
  assign sel_ctrl = (paddr == OFF_CTRL);
  assign sel_status = (paddr == OFF_STATUS);
  assign sel_mask = (paddr == OFF_MASK);
  assign sel_flag = (paddr == OFF_RSTFLAG);
  assign sel_restart = (paddr == OFF_RESTART);
  assign mapped = sel_ctrl | sel_status | sel_mask | sel_flag | sel_restart;
  assign wr_ctrl = wr_take & sel_ctrl & ~pslverr;
  assign wr_restart = (wr_take & sel_restart & ~pslverr) | restart_instruction;
  assign wd = fgw_ctrl_s'(pwdata[7:0]);

  // ************************************************************
  // control register
  // ************************************************************
  logic en_q;
  logic ce_q;
  logic [1:0] ce_cnt_q;
  logic [2:0] per_q;
  logic reinit;
  logic timeout_hit;
  logic en_wr;
  logic per_ok;
  logic ce_expire;
  logic refused_evt;
  fgw_ctrl_s ctrl_view;

  // a timeout resets the chip, so the block restarts its own controls too
  assign reinit = chip_rst_in | timeout_hit | strap_take;
  // level 0 period writes are free; others need the open window
  assign per_ok = is_l0 | ce_q;
  // one always enables; zero only sticks inside the window, never in level 2
  assign en_wr = wd.enable | is_l2 | (en_q & ~ce_q);
  assign ce_expire = ce_q & (ce_cnt_q == CHG_LAST);
  assign refused_evt = wr_ctrl & en_q & ~wd.enable & (~ce_q | is_l2);
  assign ctrl_view = '{rsvd: 3'h0, chg_en: ce_q, enable: en_q | is_l2,
                       period: per_q};

  // initial enable follows the level captured from the fuses
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      en_q <= 1'b0;
      per_q <= PERIOD_RESET;
    end else if (reinit) begin
      en_q <= strap_take ? (fuse_level(pins_sync[1], pins_sync[0]) == FGW_LVL2) : is_l2;
      per_q <= PERIOD_RESET;
    end else if (wr_ctrl) begin
      en_q <= en_wr;
      per_q <= per_ok ? wd.period : per_q;
    end
  end

  // change-enable window: counts clocks from the write that opened it
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ce_q <= 1'b0;
      ce_cnt_q <= 2'h0;
    end else if (reinit) begin
      ce_q <= 1'b0;
      ce_cnt_q <= 2'h0;
    end else if (wr_ctrl) begin
      ce_q <= wd.chg_en;
      ce_cnt_q <= 2'h0;
    end else begin
      ce_q <= ce_q & ~ce_expire;
      ce_cnt_q <= ce_q ? ce_cnt_q + 2'h1 : 2'h0;
    end
  end

  // ************************************************************
  // timeout counter
  // ************************************************************
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] limit;
  logic cnt_clr;

  // last count before expiry; base doubles per code
  function automatic logic [CNT_W-1:0] period_limit(input logic [2:0] sel);
    return CNT_W'((PERIOD_BASE << sel) - 1);
  endfunction : period_limit

  assign limit = period_limit(per_q);
  // >= guards a period shortened below the running count
  assign timeout_hit = en_q & osc_tick & (cnt_q >= limit);
  assign cnt_clr = ~en_q | wr_restart | timeout_hit | reinit;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (cnt_clr) begin
      cnt_q <= '0;
    end else if (osc_tick) begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  // ************************************************************
  // reset pulse, flag, status and interrupt
  // ************************************************************
  logic flag_q;
  logic [STS_W-1:0] sts_q;
  logic [STS_W-1:0] mask_q;
  fgw_evt_s evt;
  logic [STS_W-1:0] sts_clr;
  logic flag_clr;

  assign evt = '{refused: refused_evt, timeout: timeout_hit};
  assign sts_clr = (wr_take & sel_status) ? pwdata[STS_W-1:0] : '0;
  assign flag_clr = wr_take & sel_flag & ~pwdata[FLAG_BIT];

  // set wins over clear on every sticky bit
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      chip_rst_pulse <= 1'b0;
      flag_q <= 1'b0;
      sts_q <= '0;
      mask_q <= '0;
      irq <= 1'b0;
    end else begin
      chip_rst_pulse <= timeout_hit;
      flag_q <= timeout_hit | (flag_q & ~flag_clr);
      sts_q <= evt | (sts_q & ~sts_clr);
      mask_q <= (wr_take & sel_mask) ? pwdata[STS_W-1:0] : mask_q;
      irq <= |(sts_q & mask_q);
    end
  end

  // ************************************************************
  // apb answer
  // ************************************************************
  // unmapped reads return zero with an error
  assign rd_mux = sel_ctrl ? {24'h00_0000, ctrl_view} :
                  sel_status ? {30'h0000_0000, sts_q} :
                  sel_mask ? {30'h0000_0000, mask_q} :
                  sel_flag ? {31'h0000_0000, flag_q} : DATA_ZERO;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= DATA_ZERO;
    end else begin
      pready <= acc_start;
      pslverr <= acc_start & ~mapped;
      prdata <= acc_start ? rd_mux : prdata;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  ce_opens_a: assert property (
    wr_ctrl && wd.chg_en && !reinit |=> ce_q && ce_cnt_q == 2'h0)
    else $error("change-enable did not open");

  ce_window_a: assert property (
    ce_q && ce_cnt_q == 2'h0 && !wr_ctrl && !reinit
      ##1 (!wr_ctrl && !reinit) [*3] |=> !ce_q)
    else $error("change-enable window not four cycles");

  reserved_zero_a: assert property (
    pready && $past(acc_start && sel_ctrl) |-> prdata[7:5] == 3'h0)
    else $error("reserved control bits not zero");

  level2_reads_a: assert property (
    pready && $past(acc_start && sel_ctrl) && is_l2 |-> prdata[3])
    else $error("enable reads zero in level 2");

  level2_on_a: assert property (
    init_done_q && is_l2 |-> en_q)
    else $error("watchdog disabled in level 2");

  disable_guard_a: assert property (
    en_q && wr_ctrl && !ce_q && !reinit |=> en_q)
    else $error("disabled without change-enable");

  period_guard_a: assert property (
    wr_ctrl && !is_l0 && !ce_q && !reinit |=> $stable(per_q))
    else $error("period changed without change-enable");

  restart_clear_a: assert property (
    wr_restart |=> cnt_q == '0)
    else $error("restart did not clear counter");

  disabled_clear_a: assert property (
    !en_q |=> cnt_q == '0)
    else $error("counter runs while disabled");

  timeout_fire_a: assert property (
    en_q && osc_tick && cnt_q == limit && !wr_restart
      |=> chip_rst_pulse && flag_q ##1 !chip_rst_pulse)
    else $error("timeout did not give a one-cycle reset");

  pulse_cause_a: assert property (
    $rose(chip_rst_pulse) |-> $past(en_q) && $past(osc_tick))
    else $error("reset pulse without expiry");

  pulse_single_a: assert property (
    chip_rst_pulse |=> !chip_rst_pulse)
    else $error("reset pulse longer than one cycle");

  flag_hold_a: assert property (
    flag_q && !flag_clr |=> flag_q)
    else $error("reset flag lost without a zero write");

  enable_write_a: assert property (
    wr_ctrl && wd.enable && !reinit |=> en_q)
    else $error("enable write of one ignored");

  chip_reload_a: assert property (
    chip_rst_in |=> cnt_q == '0 && !ce_q && en_q == is_l2)
    else $error("chip reset did not reload control");

  tick_only_a: assert property (
    !osc_tick && !cnt_clr |=> $stable(cnt_q))
    else $error("counter moved without an oscillator tick");

  free_period_a: assert property (
    wr_ctrl && is_l0 && !reinit |=> per_q == $past(wd.period))
    else $error("level 0 period write not taken");

endmodule : fgw_watchdog

// ---- tb/tb.sv ----
/*
  Self-checking bench for the fuse-guarded watchdog: an APB master, a table
  of register cases, then restart, timeout, interrupt, chip reset, level 2.
  Assumes fgw_pkg and fgw_watchdog are compiled ahead of this file.
*/
`timescale 1ns/1ps
module tb;
  import fgw_pkg::*;
  // ************************************************************
  // signals
  // ************************************************************
  localparam int unsigned BASE = 4; // short base keeps code 7 affordable
  typedef struct packed {
    logic [7:0] a;
    logic w;
    logic [7:0] d;
    logic [7:0] e;
    logic err;
  } fgw_row_s;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic osc_clk_pin = 1'b0;
  logic compat_fuse = 1'b0;
  logic always_on_fuse = 1'b0;
  logic restart_instruction = 1'b0;
  logic chip_rst_in = 1'b0;
  logic chip_rst_pulse;
  logic irq;
  int error_cnt = 0;
  int total_checks = 0;
  int osc_div = 0;
  int pulse_cnt = 0;
  int p0;
  logic [31:0] q;
  logic e;
  string nm;
  // level 1 cases, back to back so change-enable windows line up
  fgw_row_s rows [24] = '{
    '{OFF_CTRL, 0, 8'h00, 8'h00, 0}, '{OFF_CTRL, 1, 8'h0F, 8'h00, 0},
    '{OFF_CTRL, 0, 8'h00, 8'h08, 0}, '{OFF_CTRL, 1, 8'hE8, 8'h00, 0},
    '{OFF_CTRL, 0, 8'h00, 8'h08, 0}, '{OFF_CTRL, 1, 8'h00, 8'h00, 0},
    '{OFF_CTRL, 0, 8'h00, 8'h08, 0}, '{OFF_STATUS, 0, 8'h00, 8'h02, 0},
    '{OFF_STATUS, 1, 8'h02, 8'h00, 0}, '{OFF_STATUS, 0, 8'h00, 8'h00, 0},
    '{OFF_CTRL, 1, 8'h18, 8'h00, 0}, '{OFF_CTRL, 0, 8'h00, 8'h18, 0},
    '{OFF_CTRL, 1, 8'h00, 8'h00, 0}, '{OFF_CTRL, 0, 8'h00, 8'h08, 0},
    '{OFF_CTRL, 1, 8'h18, 8'h00, 0}, '{OFF_CTRL, 1, 8'h0D, 8'h00, 0},
    '{OFF_CTRL, 0, 8'h00, 8'h0D, 0}, '{OFF_CTRL, 1, 8'h18, 8'h00, 0},
    '{OFF_CTRL, 1, 8'h00, 8'h00, 0}, '{OFF_CTRL, 0, 8'h00, 8'h00, 0},
    '{OFF_MASK, 1, 8'h03, 8'h00, 0}, '{OFF_MASK, 0, 8'h00, 8'h03, 0},
    '{8'h14, 0, 8'h00, 8'h00, 1}, '{8'h14, 1, 8'h55, 8'h00, 1}};

  fgw_watchdog #(.PERIOD_BASE(BASE)) DUT (
    .clock(clock), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .osc_clk_pin(osc_clk_pin),
    .compat_fuse(compat_fuse), .always_on_fuse(always_on_fuse),
    .restart_instruction(restart_instruction), .chip_rst_in(chip_rst_in),
    .chip_rst_pulse(chip_rst_pulse), .irq(irq));

  // ************************************************************
  // clock, oscillator and pulse monitor
  // ************************************************************
  // 50 MHz system clock
  always #10 clock = ~clock;
  // oscillator at 1 MHz, phase unrelated to any transfer
  always @(posedge clock) begin
    osc_div <= (osc_div == 24) ? 0 : osc_div + 1;
    if (osc_div == 24) begin
      osc_clk_pin <= ~osc_clk_pin;
    end
  end
  // counting pulses means a one-cycle pulse is never missed
  always @(posedge clock) begin
    if (chip_rst_pulse === 1'b1) begin
      pulse_cnt <= pulse_cnt + 1;
    end
  end

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic give_verdict();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check

  // entered just after an edge; the caller releases with rel
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] rq, output logic rerr);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rq = prdata;
    rerr = pslverr;
    if (pready !== 1'b1) begin
      error_cnt++;
      give_verdict();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, q, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    apb(a, 1'b0, DATA_ZERO, q, e);
    check(name, q, exp);
  endtask : rd

  task automatic rel(input int cyc);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (cyc) @(posedge clock);
  endtask : rel

  // fuses only settle under power-on reset
  task automatic do_reset(input logic c, input logic a);
    sys_rst <= 1'b1;
    compat_fuse <= c;
    always_on_fuse <= a;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
  endtask : do_reset

  // a restart, then the oscillator ticks until the pulse
  task automatic run_to(input logic [2:0] code);
    int n;
    int lim;
    int p;
    lim = BASE << code;
    wr(OFF_CTRL, 32'h0000_0008 | 32'(code));
    wr(OFF_RESTART, DATA_ZERO);
    rel(1);
    p = pulse_cnt;
    n = 0;
    while (pulse_cnt == p && n < lim * 50 + 100) begin
      @(posedge clock);
      n++;
    end
    // no pulse at all: the run cannot go on meaningfully
    if (pulse_cnt == p) begin
      error_cnt++;
      give_verdict();
    end
    check("timeout cycles", 32'(n >= (lim - 1) * 50 && n <= lim * 50 + 10), 32'h1);
    repeat (3) @(posedge clock);
    check("pulse count", 32'(pulse_cnt - p), 32'h1);
  endtask : run_to

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    do_reset(1'b0, 1'b0);
    for (int i = 0; i < 24; i++) begin
      apb(rows[i].a, rows[i].w, 32'(rows[i].d), q, e);
      if (!rows[i].w) begin
        nm = $sformatf("row %0d data", i);
        check(nm, q, 32'(rows[i].e));
      end
      check($sformatf("row %0d error", i), 32'(e), 32'(rows[i].err));
    end
    rel(3);
    check("irq raised", 32'(irq), 32'h1);
    wr(OFF_STATUS, 32'h0000_0002);
    rel(3);
    check("irq cleared", 32'(irq), 32'h0);
    // level 0: restarts hold off expiry, period changes freely
    do_reset(1'b1, 1'b0);
    wr(OFF_CTRL, 32'h0000_0008);
    rel(1);
    p0 = pulse_cnt;
    repeat (10) begin
      repeat (100) @(posedge clock);
      restart_instruction <= 1'b1;
      @(posedge clock);
      restart_instruction <= 1'b0;
    end
    check("pulses while restarted", 32'(pulse_cnt - p0), 32'h0);
    for (int c = 0; c < 8; c++) begin
      run_to(3'(c));
    end
    rd(OFF_RSTFLAG, 32'h0000_0001, "reset flag");
    rd(OFF_STATUS, 32'h0000_0001, "status after timeout");
    rd(OFF_CTRL, 32'h0000_0000, "control after timeout");
    rel(3);
    check("irq masked", 32'(irq), 32'h0);
    wr(OFF_MASK, 32'h0000_0001);
    rel(3);
    check("irq unmasked", 32'(irq), 32'h1);
    wr(OFF_STATUS, 32'h0000_0001);
    rel(3);
    check("irq after clear", 32'(irq), 32'h0);
    // chip reset reloads control but keeps the flag
    wr(OFF_CTRL, 32'h0000_000B);
    rel(1);
    chip_rst_in <= 1'b1;
    @(posedge clock);
    chip_rst_in <= 1'b0;
    @(posedge clock);
    rd(OFF_CTRL, 32'h0000_0000, "control after chip reset");
    rd(OFF_RSTFLAG, 32'h0000_0001, "flag after chip reset");
    wr(OFF_RSTFLAG, 32'h0000_0001);
    rd(OFF_RSTFLAG, 32'h0000_0001, "flag after write one");
    wr(OFF_RSTFLAG, 32'h0000_0000);
    rd(OFF_RSTFLAG, 32'h0000_0000, "flag after write zero");
    rel(1);
    // level 2: always on, period only through the timed sequence
    do_reset(1'b1, 1'b1);
    rd(OFF_CTRL, 32'h0000_0008, "level 2 start");
    wr(OFF_CTRL, 32'h0000_0018);
    wr(OFF_CTRL, 32'h0000_0000);
    rd(OFF_CTRL, 32'h0000_0008, "level 2 disable");
    wr(OFF_CTRL, 32'h0000_0018);
    wr(OFF_CTRL, 32'h0000_0003);
    rd(OFF_CTRL, 32'h0000_000B, "level 2 period");
    wr(OFF_CTRL, 32'h0000_0004);
    rd(OFF_CTRL, 32'h0000_000B, "level 2 plain period");
    rel(1);
    do_reset(1'b0, 1'b1);
    rd(OFF_CTRL, 32'h0000_0008, "always-on only");
    rel(1);
    give_verdict();
  end
endmodule : tb
